//--- hdl/timer_capture_defs.vh
`ifndef TIMER_CAPTURE_DEFS_VH
`define TIMER_CAPTURE_DEFS_VH

// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_CAP_EN_FLAGS    8'h92
`define IDX_CAP_EDGE_SEL    8'h93
`define IDX_CAP_FILT_EN     8'h94
`define IDX_TMR_CTRL        8'hC8
`define IDX_TMR_MODE        8'hC9
`define IDX_RLD_CMP_LOW     8'hCA
`define IDX_RLD_CMP_HIGH    8'hCB
`define IDX_CNT_LOW         8'hCC
`define IDX_CNT_HIGH        8'hCD
`define IDX_RES0_LOW        8'hE4
`define IDX_RES0_HIGH       8'hE5
`define IDX_RES1_LOW        8'hE6
`define IDX_RES1_HIGH       8'hE7
`define IDX_RES2_LOW        8'hED
`define IDX_RES2_HIGH       8'hEE
`define IDX_PIN_SEL_A       8'hF1
`define IDX_PIN_SEL_B       8'hF2
`define IDX_INT_EN          8'hF8

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_FLAG_BIT       7
`define CTRL_RUN_BIT        2
`define CTRL_MODE_BIT       0
`define MODE_RLD_EN_BIT     7
`define MODE_CLR_CAP_BIT    3
`define MODE_CLR_MATCH_BIT  2
`define MODE_TRIG_LSB       0
`define CH_EN_LSB           4
`define CH_FLAG_LSB         0
`define CH_FILT_LSB         4
`define INT_CAP_IE_BIT      2
`define INT_GLOBAL_IE_BIT   7

// ----------------------------------------
// encodings, reset values, timing
// ----------------------------------------
`define EDGE_FALL           2'h0
`define EDGE_RISE           2'h1
`define EDGE_ANY            2'h2
`define TRIG_OVERFLOW       2'h0
`define REG_RESET           8'h00
`define CNT_RESET           16'h0000
`define CNT_MAX             16'hFFFF
`define FILTER_CYCLES       3'h4

`endif

//--- hdl/pin_select_mux.v
`timescale 1ns/1ps
`include "timer_capture_defs.vh"

module pin_select_mux #(
	parameter PINS = 9
) (
	// selection
	input  wire [3:0]      sel,
	// pins
	input  wire [PINS-1:0] pins,
	output reg             pinOut
);

	// ----------------------------------------
	// out-of-range codes fall back to pin 0
	// ----------------------------------------
	always @*
	begin
		if (sel < PINS)
			pinOut = pins[sel];
		else
			pinOut = pins[0];
	end

endmodule // pin_select_mux

//--- hdl/capture_channel.v
`timescale 1ns/1ps
`include "timer_capture_defs.vh"

module capture_channel (
	// clock and reset
	input  wire       clk,
	input  wire       srst,
	// pin, asynchronous
	input  wire       pinRaw,
	// control
	input  wire       filterEn,
	input  wire [1:0] edgeSel,
	input  wire       chanEn,
	// event pulse
	output reg        captureEvt
);

	reg       sync1_ff;
	reg       sync2_ff;
	reg       sync3_ff;
	reg       stable_ff;
	reg       filtered_ff;
	reg       prev_ff;
	reg [2:0] glitchCnt_ff;
	wire      rise;
	wire      fall;
	reg       hit;

	// ----------------------------------------
	// synchroniser: change accepted once stages 2 and 3 agree
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (srst)
		begin
			sync1_ff  <= 1'b0;
			sync2_ff  <= 1'b0;
			sync3_ff  <= 1'b0;
			stable_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= pinRaw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			if (sync2_ff == sync3_ff)
				stable_ff <= sync3_ff;
		end
	end

	// ----------------------------------------
	// glitch filter: level must hold four cycles
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (srst)
		begin
			filtered_ff  <= 1'b0;
			glitchCnt_ff <= 3'h0;
		end
		else if (!filterEn)
		begin
			filtered_ff  <= stable_ff;
			glitchCnt_ff <= 3'h0;
		end
		else if (stable_ff != filtered_ff)
		begin
			if (glitchCnt_ff == `FILTER_CYCLES - 3'h1)
			begin
				filtered_ff  <= stable_ff;
				glitchCnt_ff <= 3'h0;
			end
			else
				glitchCnt_ff <= glitchCnt_ff + 3'h1;
		end
		else
			glitchCnt_ff <= 3'h0;
	end

	// ----------------------------------------
	// edge detector, private to this channel
	// ----------------------------------------
	assign rise = filtered_ff & ~prev_ff;
	assign fall = ~filtered_ff & prev_ff;

	always @*
	begin
		case (edgeSel)
			`EDGE_FALL: hit = fall;
			`EDGE_RISE: hit = rise;
			`EDGE_ANY:  hit = rise | fall;
			default:    hit = 1'b0;
		endcase
	end

	always @(posedge clk)
	begin
		if (srst)
		begin
			prev_ff    <= 1'b0;
			captureEvt <= 1'b0;
		end
		else
		begin
			prev_ff    <= filtered_ff;
			captureEvt <= hit & chanEn;
		end
	end

endmodule // capture_channel

//--- hdl/timer_reload_compare_capture.v
// Contract
// - Mode bit clear selects auto-reload; reload/compare pair holds reload value.
// - Auto-reload with reload enable copies the pair into counter on reload event.
// - Reload event is overflow or one enabled channel's capture, per trigger field.
// - Clear-on-capture in auto-reload: capture only zeroes counter, no reload.
// - Mode bit set selects compare; pair is the 16-bit compare value.
// - In compare mode a counter match sets the timer event flag.
// - Clear-on-match in compare mode zeroes the counter after a match.
// - Three channels, each picking one of nine shared pins.
// - Per-channel glitch filter rejects pulses under four clocks when enabled.
// - Edge field: 00 falling, 01 rising, 10 either, 11 reserved.
// - Independent edge detectors per channel, one shared counter.
// - Selected edge stores the 16-bit counter into that channel's result.
// - Capture sets channel n flag at bit n.
// - Shared request needs capture and global interrupt enables both set.
// - Clear-on-capture: capture counter value first, then zero the counter.
// - Result kept as separately addressed low and high bytes.
// - Trigger field: 00 overflow, 01 channel 0, 10 channel 1, 11 channel 2.
// - Clear-on-capture only in auto-reload; clear-on-match only in compare.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "timer_capture_defs.vh"

module timer_reload_compare_capture #(
	parameter PINS     = 9,
	parameter CHANNELS = 3
) (
	// clock and reset
	input  wire            clk,
	input  wire            srst,
	// avalon-mm slave, word addressed
	input  wire [7:0]      address,
	input  wire            read,
	input  wire            write,
	input  wire [31:0]     writedata,
	input  wire [3:0]      byteenable,
	output reg  [31:0]     readdata,
	output wire            waitrequest,
	// capture pins
	input  wire [PINS-1:0] capturePin,
	// shared capture request
	output wire            captureIrq
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [7:0]          ctrl_ff;
	reg  [7:0]          mode_ff;
	reg  [7:0]          rldCmpLow_ff;
	reg  [7:0]          rldCmpHigh_ff;
	reg  [15:0]         cnt_ff;
	reg  [CHANNELS-1:0] chanEn_ff;
	reg  [CHANNELS-1:0] capFlag_ff;
	reg  [5:0]          edgeSel_ff;
	reg  [CHANNELS-1:0] filtEn_ff;
	reg  [7:0]          pinSelA_ff;
	reg  [3:0]          pinSelB_ff;
	reg  [7:0]          intEn_ff;
	reg  [15:0]         result_ff [0:CHANNELS-1];
	reg                 readAck_ff;

	reg  [15:0]         nxt_cnt;
	reg                 nxt_tmrFlag;
	reg  [31:0]         nxt_readdata;

	wire [CHANNELS-1:0] captureEvt;
	wire [CHANNELS-1:0] selPin;
	wire [3:0]          pinSel [0:CHANNELS-1];
	wire [7:0]          resLowIdx [0:CHANNELS-1];
	wire [7:0]          resHighIdx [0:CHANNELS-1];
	wire                wrLow;
	wire [7:0]          wrByte;

	wire                compareMode;
	wire                running;
	wire [15:0]         rldCmp;
	wire                overflow;
	wire                match;
	wire                anyCapture;
	reg                 reloadEvt;

	assign wrLow  = write & byteenable[0];
	assign wrByte = writedata[7:0];

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// reads wait one cycle so read data comes from a flop; writes never wait
	assign waitrequest = read & ~readAck_ff;

	always @(posedge clk)
	begin
		if (srst)
			readAck_ff <= 1'b0;
		else
			readAck_ff <= read & ~readAck_ff;
	end

	// ----------------------------------------
	// channels
	// ----------------------------------------
	assign pinSel[0] = pinSelA_ff[3:0];
	assign pinSel[1] = pinSelA_ff[7:4];
	assign pinSel[2] = pinSelB_ff;

	// the third result pair sits apart from the first two, so each index is spelled out
	assign resLowIdx[0]  = `IDX_RES0_LOW;
	assign resHighIdx[0] = `IDX_RES0_HIGH;
	assign resLowIdx[1]  = `IDX_RES1_LOW;
	assign resHighIdx[1] = `IDX_RES1_HIGH;
	assign resLowIdx[2]  = `IDX_RES2_LOW;
	assign resHighIdx[2] = `IDX_RES2_HIGH;

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch = ch + 1)
		begin : gChan
			pin_select_mux #(
				.PINS (PINS)
			) uMux (
				.sel    (pinSel[ch]),
				.pins   (capturePin),
				.pinOut (selPin[ch])
			);

			capture_channel uChan (
				.clk        (clk),
				.srst       (srst),
				.pinRaw     (selPin[ch]),
				.filterEn   (filtEn_ff[ch]),
				.edgeSel    (edgeSel_ff[2*ch+1:2*ch]),
				.chanEn     (chanEn_ff[ch]),
				.captureEvt (captureEvt[ch])
			);

			// capture wins over a software write in the same cycle
			always @(posedge clk)
			begin
				if (srst)
					result_ff[ch] <= `CNT_RESET;
				else if (captureEvt[ch])
					result_ff[ch] <= cnt_ff;
				else if (wrLow && address == resLowIdx[ch])
					result_ff[ch][7:0] <= wrByte;
				else if (wrLow && address == resHighIdx[ch])
					result_ff[ch][15:8] <= wrByte;
			end

			// set wins over a clearing write
			always @(posedge clk)
			begin
				if (srst)
					capFlag_ff[ch] <= 1'b0;
				else if (captureEvt[ch])
					capFlag_ff[ch] <= 1'b1;
				else if (wrLow && address == `IDX_CAP_EN_FLAGS)
					capFlag_ff[ch] <= wrByte[`CH_FLAG_LSB + ch];
			end
		end
	endgenerate

	assign captureIrq = (|capFlag_ff) & intEn_ff[`INT_CAP_IE_BIT] & intEn_ff[`INT_GLOBAL_IE_BIT];

	// ----------------------------------------
	// timer control decode
	// ----------------------------------------
	assign compareMode = ctrl_ff[`CTRL_MODE_BIT];
	assign running     = ctrl_ff[`CTRL_RUN_BIT];
	assign rldCmp      = {rldCmpHigh_ff, rldCmpLow_ff};
	assign overflow    = running & (cnt_ff == `CNT_MAX);
	assign match       = compareMode & (cnt_ff == rldCmp);
	assign anyCapture  = |captureEvt;

	always @*
	begin
		case (mode_ff[`MODE_TRIG_LSB+1:`MODE_TRIG_LSB])
			`TRIG_OVERFLOW: reloadEvt = overflow;
			2'h1:           reloadEvt = captureEvt[0];
			2'h2:           reloadEvt = captureEvt[1];
			default:        reloadEvt = captureEvt[2];
		endcase
	end

	// ----------------------------------------
	// counter
	// ----------------------------------------
	// software writes to the counter bytes override hardware updates
	always @*
	begin
		nxt_cnt = cnt_ff;
		if (running)
			nxt_cnt = cnt_ff + 16'h0001;
		if (!compareMode)
		begin
			if (mode_ff[`MODE_CLR_CAP_BIT])
			begin
				if (anyCapture)
					nxt_cnt = `CNT_RESET;
				else if (mode_ff[`MODE_RLD_EN_BIT] && overflow && reloadEvt)
					nxt_cnt = rldCmp;
			end
			else if (mode_ff[`MODE_RLD_EN_BIT] && reloadEvt)
				nxt_cnt = rldCmp;
		end
		else if (match && mode_ff[`MODE_CLR_MATCH_BIT])
			nxt_cnt = `CNT_RESET;
		if (wrLow && address == `IDX_CNT_LOW)
			nxt_cnt = {nxt_cnt[15:8], wrByte};
		if (wrLow && address == `IDX_CNT_HIGH)
			nxt_cnt = {wrByte, nxt_cnt[7:0]};
	end

	// overflow flags in auto-reload, match flags in compare; set wins over clear
	always @*
	begin
		nxt_tmrFlag = ctrl_ff[`CTRL_FLAG_BIT];
		if (wrLow && address == `IDX_TMR_CTRL)
			nxt_tmrFlag = wrByte[`CTRL_FLAG_BIT];
		if (compareMode ? match : overflow)
			nxt_tmrFlag = 1'b1;
	end

	always @(posedge clk)
	begin
		if (srst)
			cnt_ff <= `CNT_RESET;
		else
			cnt_ff <= nxt_cnt;
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_ff       <= `REG_RESET;
			mode_ff       <= `REG_RESET;
			rldCmpLow_ff  <= `REG_RESET;
			rldCmpHigh_ff <= `REG_RESET;
			chanEn_ff     <= {CHANNELS{1'b0}};
			edgeSel_ff    <= 6'h00;
			filtEn_ff     <= {CHANNELS{1'b0}};
			pinSelA_ff    <= `REG_RESET;
			pinSelB_ff    <= 4'h0;
			intEn_ff      <= `REG_RESET;
		end
		else
		begin
			ctrl_ff[`CTRL_FLAG_BIT] <= nxt_tmrFlag;
			if (wrLow)
			begin
				case (address)
					`IDX_TMR_CTRL:
					begin
						ctrl_ff[`CTRL_RUN_BIT]  <= wrByte[`CTRL_RUN_BIT];
						ctrl_ff[`CTRL_MODE_BIT] <= wrByte[`CTRL_MODE_BIT];
					end
					`IDX_TMR_MODE:     mode_ff       <= wrByte & 8'h8F;
					`IDX_RLD_CMP_LOW:  rldCmpLow_ff  <= wrByte;
					`IDX_RLD_CMP_HIGH: rldCmpHigh_ff <= wrByte;
					`IDX_CAP_EN_FLAGS: chanEn_ff     <= wrByte[`CH_EN_LSB+CHANNELS-1:`CH_EN_LSB];
					`IDX_CAP_EDGE_SEL: edgeSel_ff    <= wrByte[5:0];
					`IDX_CAP_FILT_EN:  filtEn_ff     <= wrByte[`CH_FILT_LSB+CHANNELS-1:`CH_FILT_LSB];
					`IDX_PIN_SEL_A:    pinSelA_ff    <= wrByte;
					`IDX_PIN_SEL_B:    pinSelB_ff    <= wrByte[3:0];
					`IDX_INT_EN:       intEn_ff      <= wrByte & 8'h84;
					default:           ctrl_ff[1]    <= ctrl_ff[1];
				endcase
			end
		end
	end

	// ----------------------------------------
	// read mux, registered
	// ----------------------------------------
	always @*
	begin
		nxt_readdata = 32'h00000000;
		case (address)
			`IDX_TMR_CTRL:     nxt_readdata[7:0] = ctrl_ff;
			`IDX_TMR_MODE:     nxt_readdata[7:0] = mode_ff;
			`IDX_RLD_CMP_LOW:  nxt_readdata[7:0] = rldCmpLow_ff;
			`IDX_RLD_CMP_HIGH: nxt_readdata[7:0] = rldCmpHigh_ff;
			`IDX_CNT_LOW:      nxt_readdata[7:0] = cnt_ff[7:0];
			`IDX_CNT_HIGH:     nxt_readdata[7:0] = cnt_ff[15:8];
			`IDX_CAP_EN_FLAGS: nxt_readdata[7:0] = {1'b0, chanEn_ff, 1'b0, capFlag_ff};
			`IDX_CAP_EDGE_SEL: nxt_readdata[7:0] = {2'h0, edgeSel_ff};
			`IDX_CAP_FILT_EN:  nxt_readdata[7:0] = {1'b0, filtEn_ff, 4'h0};
			`IDX_RES0_LOW:     nxt_readdata[7:0] = result_ff[0][7:0];
			`IDX_RES0_HIGH:    nxt_readdata[7:0] = result_ff[0][15:8];
			`IDX_RES1_LOW:     nxt_readdata[7:0] = result_ff[1][7:0];
			`IDX_RES1_HIGH:    nxt_readdata[7:0] = result_ff[1][15:8];
			`IDX_RES2_LOW:     nxt_readdata[7:0] = result_ff[2][7:0];
			`IDX_RES2_HIGH:    nxt_readdata[7:0] = result_ff[2][15:8];
			`IDX_PIN_SEL_A:    nxt_readdata[7:0] = pinSelA_ff;
			`IDX_PIN_SEL_B:    nxt_readdata[7:0] = {4'h0, pinSelB_ff};
			`IDX_INT_EN:       nxt_readdata[7:0] = intEn_ff;
			default:           nxt_readdata = 32'h00000000;
		endcase
	end

	always @(posedge clk)
	begin
		if (srst)
			readdata <= 32'h00000000;
		else if (read && !readAck_ff)
			readdata <= nxt_readdata;
	end

endmodule // timer_reload_compare_capture

//--- tb/timer_reload_compare_capture_assertions.sv
`timescale 1ns/1ps
module timer_capture_checker #(
	parameter PINS = 9
) (
	// clock and reset
	input wire            clk,
	input wire            srst,
	// register bus
	input wire [7:0]      address,
	input wire            read,
	input wire            write,
	input wire [31:0]     writedata,
	input wire [3:0]      byteenable,
	input wire [31:0]     readdata,
	input wire            waitrequest,
	// pins and request
	input wire [PINS-1:0] capturePin,
	input wire            captureIrq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ----------------------------------------
	// pin activity age
	// ----------------------------------------
	reg [PINS-1:0] pinPrev_ff;
	reg [4:0]      quiet_ff;
	// saturates so a long idle never wraps into a false pin cause
	always @(posedge clk)
	begin
		pinPrev_ff <= capturePin;
		if (srst || capturePin != pinPrev_ff)
			quiet_ff <= 5'h00;
		else if (quiet_ff != 5'h1F)
			quiet_ff <= quiet_ff + 5'h01;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_write_no_wait: assert property (write |-> !waitrequest)
		else $error("write stalled");
	a_read_first_wait: assert property ($rose(read) |-> waitrequest)
		else $error("read answered in its first cycle");
	a_read_ack_next: assert property ((read && waitrequest) ##1 read |-> !waitrequest)
		else $error("read not answered in its second cycle");
	a_upper_data_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_filter_reserved_zero: assert property (read && !waitrequest && address == 8'h94
		|-> readdata[7] == 1'b0 && readdata[3:0] == 4'h0)
		else $error("filter register reserved bits set");
	a_rdata_hold: assert property (!read |=> $stable(readdata))
		else $error("read data moved without a read");
	a_irq_sticky: assert property ($fell(captureIrq) |-> $past(write))
		else $error("request dropped without software write");
	a_irq_cause: assert property ($rose(captureIrq) |-> $past(write) || quiet_ff < 5'h18)
		else $error("request raised with no pin edge or write");
endmodule // timer_capture_checker

//--- tb/capture_pin_source.sv
`timescale 1ns/1ps
module capture_pin_source (
	// clock
	input  wire       clk,
	// pins
	output reg  [8:0] pins
);
	initial pins = 9'h000;
	// push-pull sources: a level simply stands until the next change
	task toggle(input [3:0] idx);
		begin
			@(posedge clk);
			pins[idx] <= ~pins[idx];
		end
	endtask
	task pulse(input [3:0] idx, input integer len);
		begin
			toggle(idx);
			repeat (len - 1) @(posedge clk);
			toggle(idx);
		end
	endtask
endmodule // capture_pin_source

//--- tb/tb_timer_reload_compare_capture.sv
`timescale 1ns/1ps
module tb_timer_reload_compare_capture;
	localparam PINS = 9;
	reg             clk;
	reg             srst;
	reg  [7:0]      address;
	reg             read;
	reg             write;
	reg  [31:0]     writedata;
	wire [31:0]     readdata;
	wire            waitrequest;
	wire [PINS-1:0] capturePin;
	wire            captureIrq;
	reg  [7:0]      q;
	integer         err_total;
	integer         samples_checked;

	timer_reload_compare_capture #(.PINS(PINS)) DUT (.clk(clk), .srst(srst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
		.waitrequest(waitrequest), .capturePin(capturePin), .captureIrq(captureIrq));
	capture_pin_source PS (.clk(clk), .pins(capturePin));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task complete_run;
		begin
			if (err_total == 0 && samples_checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [15:0] s, input [15:0] e);
		begin
			samples_checked++;
			if (s !== e)
			begin
				err_total++;
				$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	task bus(input [7:0] a, input w, input [7:0] d);
		integer n;
		begin
			n = 0;
			@(posedge clk);
			address <= a;
			write <= w;
			read <= !w;
			writedata <= {24'h000000, d};
			@(posedge clk);
			while (waitrequest !== 1'b0)
			begin
				n++;
				if (n > 20)
				begin
					err_total++;
					complete_run;
				end
				@(posedge clk);
			end
			q = readdata[7:0];
			read <= 1'b0;
			write <= 1'b0;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		bus(a, 1'b1, d);
	endtask
	task chkr(input [7:0] a, input [7:0] e);
		begin
			bus(a, 1'b0, 8'h00);
			chk(q, e);
		end
	endtask
	task setcnt(input [15:0] v);
		begin
			wr(8'hCC, v[7:0]);
			wr(8'hCD, v[15:8]);
		end
	endtask
	task irqis(input e);
		begin
			@(negedge clk);
			chk(captureIrq, e);
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		logic [7:0] a [0:11];
		begin
			a = '{8'h92, 8'h93, 8'h94, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hED, 8'hEE, 8'hC8, 8'hC9, 8'h00};
			for (int i = 0; i < 12; i++)
				chkr(a[i], 8'h00);
		end
	endtask
	task t_capture;
		begin
			setcnt(16'h1234);
			wr(8'hF1, 8'h50);
			wr(8'hF2, 8'h05);
			wr(8'h93, 8'h21);
			wr(8'h92, 8'h10);
			PS.pulse(0, 6);
			repeat (16) @(posedge clk);
			chkr(8'hE4, 8'h34);
			chkr(8'hE5, 8'h12);
			chkr(8'h92, 8'h11);
			irqis(1'b0);
			wr(8'hF8, 8'h04);
			irqis(1'b0);
			wr(8'hF8, 8'h84);
			irqis(1'b1);
			repeat (40) @(posedge clk);
			irqis(1'b1);
			wr(8'h92, 8'h10);
			irqis(1'b0);
		end
	endtask
	// ch1 and the disabled ch2 share pin 5
	task t_edges;
		begin
			for (int c = 0; c < 4; c++)
			begin
				wr(8'h93, {2'h0, 2'h2, c[1:0], 2'h1});
				wr(8'h92, 8'h20);
				PS.toggle(5);
				repeat (16) @(posedge clk);
				chkr(8'h92, (c == 1 || c == 2) ? 8'h22 : 8'h20);
				wr(8'h92, 8'h20);
				PS.toggle(5);
				repeat (16) @(posedge clk);
				chkr(8'h92, (c == 0 || c == 2) ? 8'h22 : 8'h20);
			end
		end
	endtask
	task t_filter;
		begin
			wr(8'h94, 8'h10);
			wr(8'h92, 8'h10);
			PS.pulse(0, 3);
			repeat (20) @(posedge clk);
			chkr(8'h92, 8'h10);
			PS.pulse(0, 8);
			repeat (20) @(posedge clk);
			chkr(8'h92, 8'h11);
			wr(8'h94, 8'h00);
		end
	endtask
	task t_reload;
		begin
			wr(8'hCA, 8'h00);
			wr(8'hCB, 8'h55);
			setcnt(16'h0000);
			wr(8'hC9, 8'h81);
			wr(8'hC8, 8'h04);
			PS.pulse(0, 6);
			repeat (16) @(posedge clk);
			wr(8'hC8, 8'h00);
			chkr(8'hCD, 8'h55);
			wr(8'hC9, 8'h89);
			setcnt(16'h7700);
			wr(8'hC8, 8'h04);
			PS.pulse(0, 6);
			repeat (16) @(posedge clk);
			wr(8'hC8, 8'h00);
			chkr(8'hCD, 8'h00);
			chkr(8'hE5, 8'h77);
			wr(8'hC9, 8'h80);
			setcnt(16'hFFF0);
			wr(8'hC8, 8'h04);
			repeat (40) @(posedge clk);
			wr(8'hC8, 8'h00);
			chkr(8'hCD, 8'h55);
		end
	endtask
	// ch2 alone on pin 1, any edge, reloading the counter on each capture
	task t_trig;
		begin
			wr(8'hCB, 8'h33);
			setcnt(16'h0000);
			wr(8'hF2, 8'h01);
			wr(8'h93, 8'h20);
			wr(8'h92, 8'h40);
			wr(8'hC9, 8'h83);
			wr(8'hC8, 8'h04);
			PS.pulse(1, 6);
			repeat (16) @(posedge clk);
			wr(8'hC8, 8'h00);
			chkr(8'hCD, 8'h33);
			chkr(8'hEE, 8'h33);
			chkr(8'h92, 8'h44);
		end
	endtask
	task t_compare;
		begin
			wr(8'hC8, 8'h00);
			wr(8'hCA, 8'h00);
			wr(8'hCB, 8'h01);
			setcnt(16'h0000);
			wr(8'hC9, 8'h04);
			wr(8'hC8, 8'h05);
			repeat (300) @(posedge clk);
			chkr(8'hC8, 8'h85);
			wr(8'hC8, 8'h01);
			chkr(8'hCD, 8'h00);
		end
	endtask

	initial
	begin
		err_total = 0;
		samples_checked = 0;
		srst = 1'b1;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_capture;
		t_edges;
		t_filter;
		t_reload;
		t_trig;
		t_compare;
		complete_run;
	end
endmodule // tb_timer_reload_compare_capture

bind timer_reload_compare_capture timer_capture_checker #(.PINS(PINS)) chkInst (.clk(clk), .srst(srst),
	.address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
	.readdata(readdata), .waitrequest(waitrequest), .capturePin(capturePin), .captureIrq(captureIrq));
